//--- hdl/gpsl_pkg.sv
`default_nettype none
package gpsl_pkg;
	// ********************************
	// Common types and sizes
	// ********************************
	typedef logic [31:0] gpsl_word_t;
	localparam int unsigned GPSL_MAX_PINS = 32;
	localparam int unsigned GPSL_GROUPS   = 2;
	localparam int unsigned GRP_NONSEC    = 0;
	localparam int unsigned GRP_SEC       = 1;

	// ********************************
	// Register byte offsets
	// ********************************
	localparam logic [11:0] OFS_OUT_VALUE   = 12'h004;
	localparam logic [11:0] OFS_OUT_SET     = 12'h008;
	localparam logic [11:0] OFS_OUT_CLEAR   = 12'h00C;
	localparam logic [11:0] OFS_IN_VALUE    = 12'h010;
	localparam logic [11:0] OFS_DIR_VALUE   = 12'h014;
	localparam logic [11:0] OFS_DIR_SET     = 12'h018;
	localparam logic [11:0] OFS_DIR_CLEAR   = 12'h01C;
	localparam logic [11:0] OFS_SENSE_FLAGS = 12'h020;
	localparam logic [11:0] OFS_NS_SRC_SEL  = 12'h024;
	localparam logic [11:0] OFS_SEC_SRC_SEL = 12'h028;
	localparam logic [11:0] OFS_PIN_CFG_LO  = 12'h200;
	localparam logic [11:0] OFS_PIN_CFG_HI  = 12'h27C;

	// ********************************
	// Pin configuration fields
	// ********************************
	localparam int unsigned CFG_DIR_BIT    = 0;
	localparam int unsigned CFG_INDISC_BIT = 1;
	localparam int unsigned CFG_PULL_LO    = 2;
	localparam int unsigned CFG_DRIVE_LO   = 8;
	localparam int unsigned CFG_SENSE_LO   = 16;
	localparam int unsigned CFG_ANALOG_BIT = 20;
	localparam gpsl_word_t  CFG_WRITABLE   = 32'h0013_070F;
	localparam gpsl_word_t  CFG_RESET      = 32'h0000_0002;
	localparam logic [1:0]  PULL_DOWN      = 2'h1;
	localparam logic [1:0]  PULL_UP        = 2'h3;
	localparam logic [1:0]  SENSE_HIGH     = 2'h2;
	localparam logic [1:0]  SENSE_LOW      = 2'h3;

	// ********************************
	// Source select and timing
	// ********************************
	localparam logic        SRC_COMBINED   = 1'b0;
	localparam logic        SRC_LATCHED    = 1'b1;
	localparam logic [1:0]  QUIET_CYCLES   = 2'h3;
	localparam logic [1:0]  OP_WRITE       = 2'h0;
	localparam logic [1:0]  OP_SET         = 2'h1;
	localparam logic [1:0]  OP_CLEAR       = 2'h2;
endpackage
`default_nettype wire

//--- hdl/gpsl_port.sv
// Overview of operation
// - One port of up to 32 pins, each with its own configuration register.
// - Config sets direction, drive, pulls, sensing, input disconnect and analog use.
// - Writable registers keep their contents across low-power states.
// - Disconnected input reads zero and is invisible to sensing.
// - Peripherals may override pin output and direction and read its input.
// - Pad change reaches the input register two clock cycles later.
// - New sense assertion needs pad inactive three cycles after output rose.
// - Sense field picks high-level or low-level detection per pin.
// - Pin sense signal is high while its configured level is present.
// - Default source: port sense is combination of per-pin sense signals.
// - Sensing works in both on state and off state.
// - Two source selects: one for secure pins, one for non-secure pins.
// - Enabling sense on an already-met pin raises sense output at once.
// - Rising pin sense sets matching flag bit; pin 0 sets bit 0.
// - Write-one clear does not clear a flag while its pin sense is high.
// - Flags clear only by written ones; a falling sense leaves them set.
// - Latched sense high while any flag set, low once all cleared.
// - Flags left after a clear give a fresh rising edge on latched sense.
// - Flags record sense even when latched sense is not the selected source.
// - Source select may drive port sense from latched sense instead.
// - Port sense goes to power wake-up and the event units, secure separate.
// - Non-secure access to secure pin bits: writes ignored, reads zero.
// - Secure source select reads zero and ignores non-secure writes.
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module gpsl_port
	import gpsl_pkg::*;
#(
	parameter int unsigned PIN_COUNT = 32
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic        avs_secure,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [31:0] pin_secure_perm,
	input  wire logic [31:0] pad_in,
	output logic      [31:0] pad_out,
	output logic      [31:0] pad_oe,
	output logic      [31:0] pad_pull_up,
	output logic      [31:0] pad_pull_down,
	output logic      [95:0] pad_drive,
	output logic      [31:0] pad_analog_en,
	input  wire logic [31:0] periph_ovr_en,
	input  wire logic [31:0] periph_out,
	input  wire logic [31:0] periph_oe,
	output logic      [31:0] periph_in,
	output logic             sense_nonsecure,
	output logic             sense_secure,
	output logic             wake_request
);
	// ********************************
	// Elaboration checks
	// ********************************
	if (PIN_COUNT < 1 || PIN_COUNT > GPSL_MAX_PINS) begin : g_bad_count
		$error("PIN_COUNT must lie between 1 and 32");
	end
	localparam gpsl_word_t PIN_MASK = gpsl_word_t'({32{1'b1}} >> (GPSL_MAX_PINS - PIN_COUNT));

	// Write, set or clear of masked bits
	function automatic gpsl_word_t apply_op(input gpsl_word_t old, input logic [1:0] op,
	                                        input gpsl_word_t val, input gpsl_word_t m);
		gpsl_word_t res;
		case (op)
			OP_SET:   res = old | (val & m);
			OP_CLEAR: res = old & ~(val & m);
			default:  res = (old & ~m) | (val & m);
		endcase
		return res;
	endfunction

	// ********************************
	// Declarations
	// ********************************
	gpsl_word_t       cfg_r [GPSL_MAX_PINS];
	gpsl_word_t       out_r;
	gpsl_word_t       flags_r;
	gpsl_word_t       flags_nxt;
	gpsl_word_t       pad_meta_r;
	gpsl_word_t       pad_sync_r;
	gpsl_word_t       raw_d_r;
	gpsl_word_t       in_conn;
	gpsl_word_t       in_val;
	gpsl_word_t       raw;
	gpsl_word_t       dir_vec;
	gpsl_word_t       dir_nxt;
	gpsl_word_t       be_m;
	gpsl_word_t       wmask;
	gpsl_word_t       rmask;
	gpsl_word_t       flag_clr;
	gpsl_word_t       rd_val;
	gpsl_word_t       grp_m [GPSL_GROUPS];
	logic             waitreq_r;
	logic [31:0]      readdata_r;
	logic             wr_go;
	logic             cfg_hit;
	logic [4:0]       cfg_idx;
	logic             cfg_ok;
	logic             clr_done_r;
	logic [1:0]       sel_r;
	logic [1:0]       lat_r;
	logic [1:0]       comb_src;
	logic [1:0]       out_sense_r;
	logic [1:0]       out_sense_nxt;
	logic [1:0]       quiet_r [GPSL_GROUPS];
	logic [31:0]      pad_out_r;
	logic [31:0]      pad_oe_r;
	logic [31:0]      pull_up_r;
	logic [31:0]      pull_dn_r;
	logic [95:0]      drive_r;
	logic [31:0]      analog_r;
	logic [31:0]      periph_in_r;
	logic             wake_r;

	// ********************************
	// Bus decode
	// ********************************
	// Byte lanes, security filter and write strobe
	always_comb begin
		be_m    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		rmask   = PIN_MASK & (avs_secure ? 32'hFFFF_FFFF : ~pin_secure_perm);
		wmask   = be_m & rmask;
		wr_go   = avs_write && !waitreq_r;
		cfg_hit = (avs_address >= OFS_PIN_CFG_LO) && (avs_address <= OFS_PIN_CFG_HI) &&
		          (avs_address[1:0] == 2'h0);
		cfg_idx = avs_address[6:2];
		cfg_ok  = cfg_hit && PIN_MASK[cfg_idx] && (avs_secure || !pin_secure_perm[cfg_idx]);
	end

	// One wait cycle, then a single ready cycle
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			waitreq_r <= 1'b1;
		end else if ((avs_read || avs_write) && waitreq_r) begin
			waitreq_r <= 1'b0;
		end else begin
			waitreq_r <= 1'b1;
		end
	end

	// Read multiplexer
	always_comb begin
		rd_val = 32'h0000_0000;
		case (avs_address)
			OFS_OUT_VALUE, OFS_OUT_SET, OFS_OUT_CLEAR: rd_val = out_r & rmask;
			OFS_IN_VALUE:                              rd_val = in_val & rmask;
			OFS_DIR_VALUE, OFS_DIR_SET, OFS_DIR_CLEAR: rd_val = dir_vec & rmask;
			OFS_SENSE_FLAGS:                           rd_val = flags_r & rmask;
			OFS_NS_SRC_SEL:                            rd_val = {31'h0000_0000, sel_r[GRP_NONSEC]};
			OFS_SEC_SRC_SEL:                           rd_val = {31'h0000_0000, sel_r[GRP_SEC] & avs_secure};
			default: begin
				if (cfg_ok) begin
					rd_val = cfg_r[cfg_idx];
				end
			end
		endcase
	end

	// Read data captured as the ready cycle opens
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			readdata_r <= 32'h0000_0000;
		end else if (avs_read && waitreq_r) begin
			readdata_r <= rd_val;
		end
	end

	// ********************************
	// Configuration and output state
	// ********************************
	// Direction bits live inside each pin config word
	always_comb begin
		for (int i = 0; i < GPSL_MAX_PINS; i++) begin
			dir_vec[i] = cfg_r[i][CFG_DIR_BIT];
		end
		dir_nxt = dir_vec;
		if (wr_go) begin
			case (avs_address)
				OFS_DIR_VALUE: dir_nxt = apply_op(dir_vec, OP_WRITE, avs_writedata, wmask);
				OFS_DIR_SET:   dir_nxt = apply_op(dir_vec, OP_SET, avs_writedata, wmask);
				OFS_DIR_CLEAR: dir_nxt = apply_op(dir_vec, OP_CLEAR, avs_writedata, wmask);
				default:       dir_nxt = dir_vec;
			endcase
		end
	end

	// Per-pin config words, retained outside reset
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < GPSL_MAX_PINS; i++) begin
				cfg_r[i] <= CFG_RESET;
			end
		end else begin
			for (int i = 0; i < GPSL_MAX_PINS; i++) begin
				cfg_r[i][CFG_DIR_BIT] <= dir_nxt[i];
			end
			if (wr_go && cfg_ok) begin
				cfg_r[cfg_idx] <= apply_op(cfg_r[cfg_idx], OP_WRITE, avs_writedata, be_m & CFG_WRITABLE);
			end
		end
	end

	// Output value, zeroed by reset, then written, set or cleared over the bus
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			out_r <= 32'h0000_0000;
		end else if (wr_go) begin
			case (avs_address)
				OFS_OUT_VALUE: out_r <= apply_op(out_r, OP_WRITE, avs_writedata, wmask);
				OFS_OUT_SET:   out_r <= apply_op(out_r, OP_SET, avs_writedata, wmask);
				OFS_OUT_CLEAR: out_r <= apply_op(out_r, OP_CLEAR, avs_writedata, wmask);
				default:       out_r <= out_r;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sel_r <= {SRC_COMBINED, SRC_COMBINED};
		end else if (wr_go && avs_byteenable[0]) begin
			if (avs_address == OFS_NS_SRC_SEL) begin
				sel_r[GRP_NONSEC] <= avs_writedata[0];
			end
			if (avs_address == OFS_SEC_SRC_SEL && avs_secure) begin
				sel_r[GRP_SEC] <= avs_writedata[0];
			end
		end
	end

	// ********************************
	// Pad side
	// ********************************
	// Two-stage pad synchroniser
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pad_meta_r <= 32'h0000_0000;
			pad_sync_r <= 32'h0000_0000;
		end else begin
			pad_meta_r <= pad_in;
			pad_sync_r <= pad_meta_r;
		end
	end

	// Input gating and per-pin level detection
	always_comb begin
		for (int i = 0; i < GPSL_MAX_PINS; i++) begin
			in_conn[i] = !cfg_r[i][CFG_INDISC_BIT] && PIN_MASK[i];
			raw[i] = in_conn[i] &&
			         (((cfg_r[i][CFG_SENSE_LO +: 2] == SENSE_HIGH) && pad_sync_r[i]) ||
			          ((cfg_r[i][CFG_SENSE_LO +: 2] == SENSE_LOW) && !pad_sync_r[i]));
		end
		in_val = pad_sync_r & in_conn;
		grp_m[GRP_NONSEC] = PIN_MASK & ~pin_secure_perm;
		grp_m[GRP_SEC]    = PIN_MASK & pin_secure_perm;
	end

	// Peripheral override of output and direction
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pad_out_r   <= 32'h0000_0000;
			pad_oe_r    <= 32'h0000_0000;
			pull_up_r   <= 32'h0000_0000;
			pull_dn_r   <= 32'h0000_0000;
			drive_r     <= 96'h0;
			analog_r    <= 32'h0000_0000;
			periph_in_r <= 32'h0000_0000;
		end else begin
			pad_out_r   <= (periph_ovr_en & periph_out) | (~periph_ovr_en & out_r & PIN_MASK);
			pad_oe_r    <= (periph_ovr_en & periph_oe) | (~periph_ovr_en & dir_vec & PIN_MASK);
			periph_in_r <= in_val;
			for (int i = 0; i < GPSL_MAX_PINS; i++) begin
				pull_up_r[i]       <= cfg_r[i][CFG_PULL_LO +: 2] == PULL_UP;
				pull_dn_r[i]       <= cfg_r[i][CFG_PULL_LO +: 2] == PULL_DOWN;
				drive_r[i*3 +: 3]  <= cfg_r[i][CFG_DRIVE_LO +: 3];
				analog_r[i]        <= cfg_r[i][CFG_ANALOG_BIT];
			end
		end
	end

	// ********************************
	// Sense flags and latched sense
	// ********************************
	// Clear mask from a write to the flag register
	always_comb begin
		flag_clr  = (wr_go && avs_address == OFS_SENSE_FLAGS) ? (avs_writedata & wmask) : 32'h0000_0000;
		flags_nxt = (flags_r & ~(flag_clr & ~raw)) | (raw & ~raw_d_r);
	end

	// Sticky flags, set wins over clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			flags_r    <= 32'h0000_0000;
			raw_d_r    <= 32'h0000_0000;
			clr_done_r <= 1'b0;
		end else begin
			flags_r    <= flags_nxt;
			raw_d_r    <= raw;
			clr_done_r <= wr_go && (avs_address == OFS_SENSE_FLAGS);
		end
	end

	// One low cycle after each clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			lat_r <= 2'h0;
		end else begin
			for (int g = 0; g < GPSL_GROUPS; g++) begin
				lat_r[g] <= !clr_done_r && (|(flags_r & grp_m[g]));
			end
		end
	end

	// ********************************
	// Port sense outputs
	// ********************************
	// Source choice and re-arm gate
	always_comb begin
		for (int g = 0; g < GPSL_GROUPS; g++) begin
			comb_src[g] = |(raw & grp_m[g]);
			out_sense_nxt[g] = (sel_r[g] == SRC_LATCHED) ? lat_r[g] :
			                   (comb_src[g] && (out_sense_r[g] || quiet_r[g] == QUIET_CYCLES));
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			out_sense_r <= 2'h0;
			wake_r      <= 1'b0;
			for (int g = 0; g < GPSL_GROUPS; g++) begin
				quiet_r[g] <= QUIET_CYCLES;
			end
		end else begin
			out_sense_r <= out_sense_nxt;
			wake_r      <= |out_sense_nxt;
			for (int g = 0; g < GPSL_GROUPS; g++) begin
				if (comb_src[g]) begin
					quiet_r[g] <= 2'h0;
				end else if (quiet_r[g] != QUIET_CYCLES) begin
					quiet_r[g] <= quiet_r[g] + 2'h1;
				end
			end
		end
	end

	// ********************************
	// Output ports
	// ********************************
	assign avs_readdata    = readdata_r;
	assign avs_waitrequest = waitreq_r;
	assign pad_out         = pad_out_r;
	assign pad_oe          = pad_oe_r;
	assign pad_pull_up     = pull_up_r;
	assign pad_pull_down   = pull_dn_r;
	assign pad_drive       = drive_r;
	assign pad_analog_en   = analog_r;
	assign periph_in       = periph_in_r;
	assign sense_nonsecure = out_sense_r[GRP_NONSEC];
	assign sense_secure    = out_sense_r[GRP_SEC];
	assign wake_request    = wake_r;

	// ********************************
	// Assertions
	// ********************************
	logic [2:0] age_r;
	logic       rose_once_r;

	// Cycles since reset and first sense rise
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			age_r       <= 3'h0;
			rose_once_r <= 1'b0;
		end else begin
			age_r       <= (age_r == 3'h7) ? age_r : age_r + 3'h1;
			rose_once_r <= rose_once_r || (out_sense_nxt[0] && !out_sense_r[0]);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	in_delay_a: assert property (age_r == 3'h7 |-> in_val == ($past(pad_in, 2) & in_conn))
		else $error("input register does not follow pad after two cycles");
	in_disc_a: assert property ((in_val & ~in_conn) == 32'h0 && (raw & ~in_conn) == 32'h0)
		else $error("disconnected pin visible");
	flag_set_a: assert property (1'b1 |=> ($past(raw & ~raw_d_r) & ~flags_r) == 32'h0)
		else $error("rising pin sense did not set flag");
	flag_hold_a: assert property (1'b1 |=> ($past(flags_r & raw) & ~flags_r) == 32'h0)
		else $error("flag cleared while pin sense high");
	flag_sticky_a: assert property (flag_clr == 32'h0 |=> ($past(flags_r) & ~flags_r) == 32'h0)
		else $error("flag dropped without a clear");
	lat_high_a: assert property ((|(flags_r & grp_m[0])) && !clr_done_r |=> lat_r[0])
		else $error("latched sense low with flags set");
	fresh_low_a: assert property (clr_done_r |=> !lat_r[0] && !lat_r[1])
		else $error("no low cycle after clear");
	rearm_a: assert property (age_r == 3'h7 && $rose(out_sense_r[0]) && $past(sel_r[0] == SRC_COMBINED)
	                          && $past(rose_once_r) |-> $past(comb_src[0]) && !$past(comb_src[0], 2)
	                          && !$past(comb_src[0], 3) && !$past(comb_src[0], 4))
		else $error("sense re-asserted without three quiet cycles");
	lat_src_a: assert property (sel_r[0] == SRC_LATCHED |=> out_sense_r[0] == $past(lat_r[0]))
		else $error("port sense not taken from latched sense");
	comb_follow_a: assert property (sel_r[0] == SRC_COMBINED && out_sense_r[0] |=>
	                                out_sense_r[0] == $past(comb_src[0]))
		else $error("port sense not following combined sense");
	sec_sel_a: assert property (wr_go && !avs_secure && avs_address == OFS_SEC_SRC_SEL |=>
	                            $stable(sel_r[1]))
		else $error("non-secure write changed secure select");
	ns_read_a: assert property (avs_read && waitreq_r && !avs_secure |=>
	                            (avs_readdata & $past(pin_secure_perm)) == 32'h0 || $past(cfg_hit) ||
	                            $past(avs_address) == OFS_NS_SRC_SEL)
		else $error("secure pin bits visible to non-secure read");

	flag_set_c: cover property (flags_r != 32'h0 ##1 clr_done_r ##2 lat_r[0]);
	rearm_c: cover property ($rose(out_sense_r[0]) ##[1:20] $rose(out_sense_r[0]));
	lat_mode_c: cover property (sel_r[0] == SRC_LATCHED && $rose(sense_nonsecure));
	ns_ignore_c: cover property (wr_go && !avs_secure && (pin_secure_perm & avs_writedata) != 32'h0);
endmodule
`default_nettype wire

//--- testbench/gpsl_pad_model.sv
`timescale 1ns/1ns
`default_nettype none
// ********************************
// Pad-side circuitry model
// ********************************
module gpsl_pad_model (
	input  wire logic [31:0] level,
	output var logic  [31:0] pad_in
);
	// Pads settle a little after the bench asks, unrelated to the clock edge
	initial pad_in = 32'h0;
	always @(level) begin
		pad_in <= #3 level;
	end
endmodule
`default_nettype wire

//--- testbench/gpsl_port_test.sv
`timescale 1ns/1ns
`default_nettype none
module gpsl_port_test;
	import gpsl_pkg::*;
	// ********************************
	// Signals and instances
	// ********************************
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [11:0] avs_address = 12'h000;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	gpsl_word_t  avs_writedata = 32'h0;
	logic        avs_secure = 1'b0;
	gpsl_word_t  avs_readdata;
	logic        avs_waitrequest;
	gpsl_word_t  perm = 32'h0;
	gpsl_word_t  pad_level = 32'h0;
	gpsl_word_t  pad_in;
	gpsl_word_t  pad_out;
	gpsl_word_t  ovr = 32'h0;
	gpsl_word_t  p_out = 32'h0;
	gpsl_word_t  p_oe = 32'h0;
	gpsl_word_t  pad_oe;
	gpsl_word_t  pull_up;
	gpsl_word_t  analog;
	gpsl_word_t  p_in;
	logic [95:0] drive;
	logic        sense_secure;
	logic        sense_nonsecure;
	logic        wake_request;
	int          failures = 0;
	int          n_tests = 0;
	int          cycles = 0;
	gpsl_word_t  exp_q[$];
	gpsl_word_t  r;

	gpsl_port i_gpsl_port (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_secure(avs_secure),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_secure_perm(perm),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pull_up), .pad_pull_down(),
		.pad_drive(drive), .pad_analog_en(analog), .periph_ovr_en(ovr), .periph_out(p_out), .periph_oe(p_oe),
		.periph_in(p_in), .sense_nonsecure(sense_nonsecure), .sense_secure(sense_secure),
		.wake_request(wake_request));
	gpsl_pad_model i_gpsl_pad_model (.level(pad_level), .pad_in(pad_in));

	always #5 clk = ~clk;

	// ********************************
	// Compare and report tasks
	// ********************************
	task automatic check_word(input gpsl_word_t got, input gpsl_word_t exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("counts: compares=%0d mismatches=%0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// ********************************
	// Avalon master
	// ********************************
	task automatic bus_op(input logic wr_en, input logic [11:0] a, input gpsl_word_t d, input logic sec);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_secure <= sec;
		if (wr_en) avs_write <= 1'b1;
		else avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input gpsl_word_t d, input logic sec);
		bus_op(1'b1, a, d, sec);
	endtask
	task automatic rd(input logic [11:0] a, input logic sec, input gpsl_word_t exp);
		exp_q.push_back(exp);
		bus_op(1'b0, a, 32'h0, sec);
	endtask

	// Read data monitor, oldest note first
	always @(posedge clk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			if (exp_q.size() == 0) check_word(avs_readdata, 32'hDEAD_BEEF);
			else check_word(avs_readdata, exp_q.pop_front());
		end
	end

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		void'($urandom(32'h3FB8B61C));
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		rd(OFS_PIN_CFG_LO, 1'b1, CFG_RESET);
		rd(OFS_SENSE_FLAGS, 1'b1, 32'h0);
		rd(OFS_NS_SRC_SEL, 1'b1, 32'h0);
		rd(12'h100, 1'b1, 32'h0);
		pad_level <= 32'h1;
		repeat (4) @(posedge clk);
		rd(OFS_IN_VALUE, 1'b1, 32'h0);
		wr(OFS_PIN_CFG_LO, 32'h0, 1'b1);
		rd(OFS_IN_VALUE, 1'b1, 32'h1);
		check_word(p_in, 32'h0000_0001);
		$display("test inputs done");
		// Pin 3 parked low before sensing
		wr(OFS_PIN_CFG_LO + 12'h00C, 32'h0002_0000, 1'b1);
		repeat (4) @(posedge clk);
		check_bit(sense_nonsecure, 1'b0);
		pad_level[3] <= 1'b1;
		repeat (8) @(posedge clk);
		check_bit(sense_nonsecure, 1'b1);
		check_bit(wake_request, 1'b1);
		rd(OFS_SENSE_FLAGS, 1'b1, 32'h8);
		wr(OFS_SENSE_FLAGS, 32'h8, 1'b1);
		rd(OFS_SENSE_FLAGS, 1'b1, 32'h8);
		pad_level[3] <= 1'b0;
		repeat (8) @(posedge clk);
		check_bit(sense_nonsecure, 1'b0);
		rd(OFS_SENSE_FLAGS, 1'b1, 32'h8);
		wr(OFS_SENSE_FLAGS, 32'h8, 1'b1);
		rd(OFS_SENSE_FLAGS, 1'b1, 32'h0);
		pad_level[4] <= 1'b1;
		repeat (6) @(posedge clk);
		wr(OFS_PIN_CFG_LO + 12'h010, 32'h0002_0000, 1'b1);
		repeat (4) @(posedge clk);
		check_bit(sense_nonsecure, 1'b1);
		wr(OFS_PIN_CFG_LO + 12'h010, 32'h0003_0000, 1'b1);
		repeat (6) @(posedge clk);
		check_bit(sense_nonsecure, 1'b0);
		pad_level[4] <= 1'b0;
		repeat (8) @(posedge clk);
		check_bit(sense_nonsecure, 1'b1);
		wr(OFS_PIN_CFG_LO + 12'h010, 32'h0, 1'b1);
		wr(OFS_SENSE_FLAGS, 32'h18, 1'b1);
		rd(OFS_SENSE_FLAGS, 1'b1, 32'h0);
		$display("test combined sense done");
		wr(OFS_NS_SRC_SEL, 32'h1, 1'b1);
		pad_level[3] <= 1'b1;
		repeat (8) @(posedge clk);
		wr(OFS_SENSE_FLAGS, 32'h8, 1'b1);
		repeat (6) @(posedge clk);
		check_bit(sense_nonsecure, 1'b1);
		pad_level[3] <= 1'b0;
		repeat (8) @(posedge clk);
		check_bit(sense_nonsecure, 1'b1);
		wr(OFS_SENSE_FLAGS, 32'h8, 1'b1);
		repeat (6) @(posedge clk);
		check_bit(sense_nonsecure, 1'b0);
		$display("test latched sense done");
		perm <= 32'h20;
		wr(OFS_OUT_VALUE, 32'hFFFF_FFFF, 1'b0);
		rd(OFS_OUT_VALUE, 1'b1, 32'hFFFF_FFDF);
		rd(OFS_OUT_VALUE, 1'b0, 32'hFFFF_FFDF);
		rd(OFS_PIN_CFG_LO + 12'h014, 1'b0, 32'h0);
		wr(OFS_SEC_SRC_SEL, 32'h1, 1'b0);
		rd(OFS_SEC_SRC_SEL, 1'b1, 32'h0);
		wr(OFS_SEC_SRC_SEL, 32'h1, 1'b1);
		rd(OFS_SEC_SRC_SEL, 1'b0, 32'h0);
		rd(OFS_SEC_SRC_SEL, 1'b1, 32'h1);
		$display("test security done");
		// Pin 5 parked low before sensing
		wr(OFS_PIN_CFG_LO + 12'h014, 32'h0002_0000, 1'b1);
		wr(OFS_PIN_CFG_LO + 12'h018, 32'h0010_050D, 1'b1);
		pad_level[5] <= 1'b1;
		repeat (8) @(posedge clk);
		check_bit(sense_secure, 1'b1);
		check_bit(sense_nonsecure, 1'b0);
		check_word(pad_oe, 32'h0000_0040);
		check_word(pull_up, 32'h0000_0040);
		check_word(drive[31:0], 32'h0014_0000);
		check_word(analog, 32'h0000_0040);
		pad_level[5] <= 1'b0;
		wr(OFS_SENSE_FLAGS, 32'h20, 1'b0);
		rd(OFS_SENSE_FLAGS, 1'b1, 32'h20);
		$display("test secure sense done");
		for (int i = 0; i < 4; i++) begin
			r = $urandom;
			wr(OFS_OUT_VALUE, r, 1'b1);
			rd(OFS_OUT_VALUE, 1'b1, r);
			ovr <= $urandom;
			p_out <= $urandom;
			p_oe <= $urandom;
			repeat (3) @(posedge clk);
			check_word(pad_out & ovr, p_out & ovr);
			check_word(pad_out & ~ovr, r & ~ovr);
			check_word(pad_oe & ovr, p_oe & ovr);
			check_word(pad_oe & ~ovr, 32'h0000_0040 & ~ovr);
		end
		$display("test override done");
		repeat (3) @(posedge clk);
		give_verdict();
	end
endmodule
`default_nettype wire
